// ===== hw/eei_top.sv
`timescale 1ns/1ns
// Operation
// - resolver: 50..1024 pulses per revolution configurable
// - resolver: one index per rev, offset shift
// - loop tracks position; reverse pulses cancel spikes
// - sincos: fixed resolution from periods, no index
// - hires incremental: 512 or 2048, index
// - square sensor: native resolution, index per rev
// - digital absolute sensor: no output
// - input decodes quadrature or pulse/direction
// - input handled down to 250 Hz
module eei_top
  import eei_pkg::*;
(
  // clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     rst_n,
  // configuration
  input  wire eei_pkg::eei_out_cfg_type out_cfg,
  input  wire eei_pkg::eei_in_mode_type in_mode,
  // motor position from sensor
  input  wire logic [eei_pkg::POS_W-1:0] motor_pos,
  // emulated encoder output
  output eei_pkg::eei_enc_out_type      enc_out,
  // encoder input
  input  wire eei_pkg::eei_enc_in_type  enc_in,
  output logic [eei_pkg::CNT_W-1:0]     in_count,
  output logic                          in_stalled
);
  import eei_pkg::*;

  // target pulses per revolution
  logic [11:0] ppr;
  logic        idx_en;
  logic        out_en;
  always_comb
  begin
    ppr    = RES_MIN;
    idx_en = 1'b1;
    out_en = 1'b1;
    case (out_cfg.sensor)
      EEI_SENS_RESOLVER:
      begin
        ppr = out_cfg.res_cfg;
        if (out_cfg.res_cfg < RES_MIN)
          ppr = RES_MIN;
        else if (out_cfg.res_cfg > RES_MAX)
          ppr = RES_MAX;
      end
      EEI_SENS_SINCOS:
      begin
        idx_en = 1'b0;
        case (out_cfg.sine_code)
          3'h0:    ppr = PPR_16;
          3'h1:    ppr = PPR_32;
          3'h2:    ppr = PPR_128;
          3'h3:    ppr = PPR_512;
          3'h4:    ppr = PPR_1024;
          default: ppr = PPR_2048;
        endcase
      end
      EEI_SENS_HIRES:
        ppr = out_cfg.sine_code[0] ? PPR_2048 : PPR_512;
      EEI_SENS_SQUARE:
        ppr = out_cfg.sensor_ppr;
      default:
      begin
        out_en = 1'b0;
        idx_en = 1'b0;
      end
    endcase
  end

  // target quarter-step count: angle * ppr * 4 / 2^16
  logic [POS_W-1:0] shifted_pos;
  logic [29:0]      prod;
  logic [13:0]      target;
  assign shifted_pos = motor_pos - out_cfg.idx_offset;
  assign prod        = 30'(shifted_pos) * 30'(ppr);
  assign target      = prod[29:14]  > 16'h3FFF ? 14'h3FFF : prod[27:14];

  // output loop state
  eei_state_type    st_reg, st_next;
  logic [13:0]      emit_reg, emit_next;    // emitted quarter steps mod 4*ppr
  logic [7:0]       gap_reg, gap_next;
  logic [1:0]       phase_reg, phase_next;
  logic             z_reg, z_next;
  logic             dir_reg, dir_next;
  logic             a_reg, a_next;
  logic             b_reg, b_next;
  logic [14:0]      span;
  logic signed [14:0] err;

  assign span = {1'b0, ppr, 2'b00};

  always_comb
  begin
    st_next    = st_reg;
    emit_next  = emit_reg;
    gap_next   = (gap_reg != 8'h00) ? gap_reg - 8'h01 : gap_reg;
    phase_next = phase_reg;
    z_next     = 1'b0;
    dir_next   = dir_reg;
    // shortest signed error around the revolution
    err = $signed({1'b0, target}) - $signed({1'b0, emit_reg});
    if (err > $signed(span >> 1))
      err = err - $signed(span);
    else if (err < -$signed(span >> 1))
      err = err + $signed(span);
    case (st_reg)
      EEI_ST_IDLE:
        st_next = out_en ? EEI_ST_TRACK : EEI_ST_OFF;
      EEI_ST_TRACK, EEI_ST_COMP:
      begin
        if (!out_en)
          st_next = EEI_ST_OFF;
        else if (err != 15'sh0 && gap_reg == 8'h00)
        begin
          // rate limited step toward target, reversing when overshot
          dir_next = (err < 15'sh0);
          st_next  = (err < 15'sh0) != dir_reg ? EEI_ST_COMP : EEI_ST_TRACK;
          gap_next = OUT_GAP;
          if (err > 15'sh0)
          begin
            phase_next = phase_reg + 2'h1;
            emit_next  = (15'(emit_reg) + 15'h1 >= span) ? 14'h0 : emit_reg + 14'h1;
          end
          else
          begin
            phase_next = phase_reg - 2'h1;
            emit_next  = (emit_reg == 14'h0) ? 14'(span - 15'h1) : emit_reg - 14'h1;
          end
          // index while passing position zero
          z_next = idx_en && (emit_next == 14'h0);
        end
      end
      EEI_ST_OFF:
        st_next = out_en ? EEI_ST_TRACK : EEI_ST_OFF;
      default:
        st_next = EEI_ST_IDLE;
    endcase
    // line levels registered so the xor cannot glitch onto the pins
    a_next = phase_next[1];
    b_next = phase_next[1] ^ phase_next[0];
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      st_reg    <= EEI_ST_IDLE;
      emit_reg  <= 14'h0;
      gap_reg   <= 8'h00;
      phase_reg <= 2'h0;
      z_reg     <= 1'b0;
      dir_reg   <= 1'b0;
      a_reg     <= 1'b0;
      b_reg     <= 1'b0;
    end
    else
    begin
      st_reg    <= st_next;
      emit_reg  <= emit_next;
      gap_reg   <= gap_next;
      phase_reg <= phase_next;
      z_reg     <= z_next;
      dir_reg   <= dir_next;
      a_reg     <= a_next;
      b_reg     <= b_next;
    end
  end

  // gray phase sequence gives a quarter period offset
  assign enc_out = '{
    a:  a_reg,
    b:  b_reg,
    z:  z_reg,
    en: (st_reg == EEI_ST_TRACK) || (st_reg == EEI_ST_COMP)
  };

  // input decode; inputs taken synchronous, previous levels only
  logic             a_prev_reg, a_prev_next;
  logic             b_prev_reg, b_prev_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [TO_W-1:0]  idle_reg, idle_next;
  logic             stall_reg, stall_next;
  logic             stepped;

  always_comb
  begin
    a_prev_next = enc_in.a;
    b_prev_next = enc_in.b;
    cnt_next    = cnt_reg;
    stepped     = 1'b0;
    if (in_mode == EEI_IN_PULSDIR)
    begin
      // a is pulse, b is direction
      if (enc_in.a && !a_prev_reg)
      begin
        stepped  = 1'b1;
        cnt_next = enc_in.b ? cnt_reg - 32'h1 : cnt_reg + 32'h1;
      end
    end
    else if ((enc_in.a ^ a_prev_reg) || (enc_in.b ^ b_prev_reg))
    begin
      stepped = 1'b1;
      // x4 decode: forward when new a differs from old b
      if (enc_in.a ^ b_prev_reg)
        cnt_next = cnt_reg + 32'h1;
      else
        cnt_next = cnt_reg - 32'h1;
    end
    // below minimum rate the input reads as stalled
    idle_next  = stepped ? '0 : (idle_reg == TO_W'(TIMEOUT_CY) ? idle_reg : idle_reg + TO_W'(1));
    stall_next = (idle_next == TO_W'(TIMEOUT_CY));
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      a_prev_reg <= 1'b0;
      b_prev_reg <= 1'b0;
      cnt_reg    <= '0;
      // saturated so the input reads stalled until its first edge
      idle_reg   <= TO_W'(TIMEOUT_CY);
      stall_reg  <= 1'b1;
    end
    else
    begin
      a_prev_reg <= a_prev_next;
      b_prev_reg <= b_prev_next;
      cnt_reg    <= cnt_next;
      idle_reg   <= idle_next;
      stall_reg  <= stall_next;
    end
  end

  assign in_count   = cnt_reg;
  assign in_stalled = stall_reg;

endmodule : eei_top

// ===== hw/eei_pkg.sv
package eei_pkg;

  // position sensor kinds
  typedef enum logic [2:0] {
    EEI_SENS_RESOLVER = 3'h0,
    EEI_SENS_SINCOS   = 3'h1,
    EEI_SENS_HIRES    = 3'h2,
    EEI_SENS_SQUARE   = 3'h3,
    EEI_SENS_DIGITAL  = 3'h4
  } eei_sensor_type;

  // input decode modes
  typedef enum logic {
    EEI_IN_QUAD    = 1'h0,
    EEI_IN_PULSDIR = 1'h1
  } eei_in_mode_type;

  // output generator states, gray along the usual path
  typedef enum logic [1:0] {
    EEI_ST_IDLE  = 2'h0,
    EEI_ST_TRACK = 2'h1,
    EEI_ST_COMP  = 2'h3,
    EEI_ST_OFF   = 2'h2
  } eei_state_type;

  localparam int POS_W = 16;   // sensor angle, one revolution = 2^16
  localparam int CNT_W = 32;

  localparam logic [11:0] RES_MIN = 12'h032;  // 50
  localparam logic [11:0] RES_MAX = 12'h400;  // 1024

  // sine period codes -> pulses per revolution
  localparam logic [11:0] PPR_16   = 12'h010;
  localparam logic [11:0] PPR_32   = 12'h020;
  localparam logic [11:0] PPR_128  = 12'h080;
  localparam logic [11:0] PPR_512  = 12'h200;
  localparam logic [11:0] PPR_1024 = 12'h400;
  localparam logic [11:0] PPR_2048 = 12'h800;

  // input frequency range and derived sample spacing
  localparam int    CLK_HZ      = 125000000;
  localparam int    FIN_MAX_HZ  = 200000;
  localparam int    FIN_MIN_HZ  = 250;
  localparam int    EDGE_MIN_CY = CLK_HZ / (FIN_MAX_HZ * 4);
  localparam int    TIMEOUT_CY  = (CLK_HZ + FIN_MIN_HZ - 1) / FIN_MIN_HZ;
  localparam int    TO_W        = 20;
  // min spacing between emitted output edges
  localparam logic [7:0] OUT_GAP = 8'(EDGE_MIN_CY);

  typedef struct packed {
    eei_sensor_type sensor;
    logic [11:0]    res_cfg;      // resolver resolution
    logic [2:0]     sine_code;    // sincos / hires period select
    logic [11:0]    sensor_ppr;   // square sensor native lines
    logic [POS_W-1:0] idx_offset;
  } eei_out_cfg_type;

  typedef struct packed {
    logic a;
    logic b;
    logic z;
    logic en;
  } eei_enc_out_type;

  typedef struct packed {
    logic a;
    logic b;
  } eei_enc_in_type;

endpackage : eei_pkg

// ===== dv/eei_top_checker.sv
`timescale 1ns/1ns
module eei_top_checker
  import eei_pkg::*;
(
  // clock and reset
  input wire logic                     ref_clk,
  input wire logic                     rst_n,
  // configuration and position
  input wire eei_pkg::eei_out_cfg_type out_cfg,
  input wire eei_pkg::eei_in_mode_type in_mode,
  input wire logic [POS_W-1:0]         motor_pos,
  // encoder lines and count
  input wire eei_pkg::eei_enc_out_type enc_out,
  input wire eei_pkg::eei_enc_in_type  enc_in,
  input wire logic [CNT_W-1:0]         in_count,
  input wire logic                     in_stalled
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // a rises, b steady: b level picks the way
  sequence s_a_edge;
    $rose(enc_in.a) && $stable(enc_in.b);
  endsequence
  property p_up;
    s_a_edge ##0 !enc_in.b |=> in_count == $past(in_count) + 32'h1;
  endproperty
  a_up: assert property (p_up) else $error("count did not step up");
  property p_dn;
    s_a_edge ##0 enc_in.b |=> in_count == $past(in_count) - 32'h1;
  endproperty
  a_dn: assert property (p_dn) else $error("count did not step down");
  property p_hold;
    in_mode == EEI_IN_QUAD && $stable(enc_in) |=> $stable(in_count);
  endproperty
  a_hold: assert property (p_hold) else $error("count moved without edge");
  property p_live;
    in_mode == EEI_IN_QUAD && $changed(enc_in) |=> !in_stalled;
  endproperty
  a_live: assert property (p_live) else $error("stalled despite edge");
  property p_dig;
    (out_cfg.sensor == EEI_SENS_DIGITAL) [*3] |-> !enc_out.en;
  endproperty
  a_dig: assert property (p_dig) else $error("output on with digital sensor");
  property p_nz;
    (out_cfg.sensor == EEI_SENS_SINCOS) [*3] |-> !enc_out.z;
  endproperty
  a_nz: assert property (p_nz) else $error("index with sincos sensor");
  property p_quad;
    !($changed(enc_out.a) && $changed(enc_out.b));
  endproperty
  a_quad: assert property (p_quad) else $error("both channels moved");
  property p_gap;
    $changed({enc_out.a, enc_out.b}) |=> $stable({enc_out.a, enc_out.b}) [*8];
  endproperty
  a_gap: assert property (p_gap) else $error("output steps too close");
  property p_z;
    $rose(enc_out.z) |=> !enc_out.z;
  endproperty
  a_z: assert property (p_z) else $error("index longer than one cycle");
endmodule : eei_top_checker

bind eei_top eei_top_checker u_eei_top_checker (
  .ref_clk(ref_clk), .rst_n(rst_n), .out_cfg(out_cfg), .in_mode(in_mode),
  .motor_pos(motor_pos), .enc_out(enc_out), .enc_in(enc_in),
  .in_count(in_count), .in_stalled(in_stalled)
);

// ===== dv/eei_enc_src.sv
`timescale 1ns/1ns
module eei_enc_src
  import eei_pkg::*;
(
  // control from bench
  input wire logic            ref_clk,
  input wire eei_in_mode_type mode,
  input wire logic            step,
  input wire logic            dir,
  // encoder lines
  output eei_pkg::eei_enc_in_type enc
);
  logic [1:0] ph_reg  = 2'h0;
  int         gap_reg = 1000;
  // phase only moves in quadrature, so a mode swap leaves lines low
  always @(posedge ref_clk)
  begin
    gap_reg <= step ? 0 : gap_reg + 1;
    if (step && mode == EEI_IN_QUAD)
      ph_reg <= dir ? ph_reg + 2'h1 : ph_reg - 2'h1;
  end
  always_comb
    if (mode == EEI_IN_QUAD)
      enc = '{a: ph_reg[1], b: ph_reg[1] ^ ph_reg[0]};
    else
      enc = '{a: gap_reg < 80, b: dir};
endmodule : eei_enc_src

// ===== dv/tb.sv
`timescale 1ns/1ns
module tb;
  import eei_pkg::*;
  logic            ref_clk, rst_n, step, dir;
  eei_out_cfg_type out_cfg;
  eei_in_mode_type in_mode;
  logic [POS_W-1:0] motor_pos;
  eei_enc_out_type enc_out;
  eei_enc_in_type  enc_in;
  logic [CNT_W-1:0] in_count, exp_cnt;
  logic            in_stalled;
  logic [1:0]      op = 2'h0;
  int              error_cnt = 0, total_checks = 0, seed = 67;
  int              oc = 0, zc = 0, b_oc, b_zc;
  eei_top u_eei_top (.ref_clk(ref_clk), .rst_n(rst_n), .out_cfg(out_cfg),
    .in_mode(in_mode), .motor_pos(motor_pos), .enc_out(enc_out), .enc_in(enc_in),
    .in_count(in_count), .in_stalled(in_stalled));
  eei_enc_src u_eei_enc_src (.ref_clk(ref_clk), .mode(in_mode), .step(step),
    .dir(dir), .enc(enc_in));
  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // quarter steps over 1/frac revolution
  function automatic int q_exp(logic [11:0] r, int frac);
    logic [11:0] c;
    c = r < RES_MIN ? RES_MIN : (r > RES_MAX ? RES_MAX : r);
    return 4 * int'(c) / frac;
  endfunction : q_exp
  // rising phase, b leading a, counts forward
  function automatic int qd(logic [1:0] o, logic [1:0] n);
    return (n - o) == 2'h1 ? 1 : ((o - n) == 2'h1 ? -1 : 0);
  endfunction : qd
  always @(posedge ref_clk)
  begin
    op <= {enc_out.a, enc_out.a ^ enc_out.b};
    oc <= oc + qd(op, {enc_out.a, enc_out.a ^ enc_out.b});
    zc <= zc + int'(enc_out.z);
  end
  task automatic chk(string n, logic [CNT_W-1:0] e, s, tol);
    total_checks++;
    if (((s - e) <= tol || (e - s) <= tol) !== 1'b1)
    begin
      error_cnt++;
      $display("ERROR %s expected %0h seen %0h", n, e, s);
    end
  endtask : chk
  task automatic finish_test;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : finish_test
  task automatic move(int n);
    repeat (n) @(posedge ref_clk) #1 motor_pos = motor_pos + 16'h0002;
    repeat (600) @(posedge ref_clk);
    #1;
  endtask : move
  // about 82k cycles of tests, so this only trips on a hang
  initial
  begin
    repeat (95000) @(posedge ref_clk);
    error_cnt++;
    finish_test();
  end
  initial
  begin
    rst_n = 1'b0; step = 1'b0; dir = 1'b0; in_mode = EEI_IN_PULSDIR; motor_pos = '0;
    out_cfg = '{EEI_SENS_RESOLVER, RES_MIN, 3'h0, 12'h400, 16'h8000};
    repeat (3) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    chk("count_rst", 32'h0, in_count, 32'h0);
    chk("stall_rst", 32'h1, in_stalled, 32'h0);
    repeat (4) @(posedge ref_clk);
    #1 chk("stall_idle", 32'h1, in_stalled, 32'h0);
    for (int m = 1; m >= 0; m--)
    begin
      in_mode = eei_in_mode_type'(m);
      exp_cnt = 32'h0;
      if (m == 0) exp_cnt = b_oc;
      repeat (24)
      begin
        dir = 1'($random(seed));
        @(posedge ref_clk) #1 step = 1'b1;
        @(posedge ref_clk) #1 step = 1'b0;
        exp_cnt = dir ? exp_cnt - 32'h1 : exp_cnt + 32'h1;
        repeat (m ? 640 : 160) @(posedge ref_clk);
        #1;
      end
      chk("in_count", exp_cnt, in_count, 32'h0);
      chk("stalled", 32'h0, in_stalled, 32'h0);
      b_oc = exp_cnt;
      dir = 1'b0;
      @(posedge ref_clk) #1;
    end
    chk("en", 32'h1, enc_out.en, 32'h0);
    for (int r = 0; r < 2; r++)
    begin
      b_oc = oc;
      b_zc = zc;
      out_cfg.res_cfg = r ? 12'h010 : RES_MIN;
      move(32768 >> r);
      chk("edges", q_exp(out_cfg.res_cfg, r + 1), oc - b_oc, 32'h2);
      if (r == 0) chk("index", 32'h1, zc - b_zc, 32'h0);
    end
    out_cfg.sensor = EEI_SENS_SINCOS;
    // start two steps short of zero so the loop must pass it
    out_cfg.idx_offset = 16'h8600;
    b_zc = zc;
    move(2000);
    chk("no_index", 32'h0, zc - b_zc, 32'h0);
    // hires 512 then square 1024 lines: settle at zero, then jump 1/256 turn
    for (int k = 0; k < 2; k++)
    begin
      out_cfg.sensor     = k ? EEI_SENS_SQUARE : EEI_SENS_HIRES;
      out_cfg.idx_offset = motor_pos;
      repeat (1500) @(posedge ref_clk);
      #1 b_oc = oc;
      motor_pos = motor_pos + 16'h0100;
      repeat (3000) @(posedge ref_clk);
      #1 exp_cnt = q_exp(k ? out_cfg.sensor_ppr : PPR_512, 256);
      chk("fixed_res", exp_cnt, oc - b_oc, 32'h0);
    end
    out_cfg.sensor = EEI_SENS_DIGITAL;
    repeat (3) @(posedge ref_clk);
    #1 chk("en_off", 32'h0, enc_out.en, 32'h0);
    b_oc = oc;
    move(400);
    chk("frozen", 32'h0, oc - b_oc, 32'h0);
    finish_test();
  end
endmodule : tb
